/* File: hdl/shpf_host_port.v */
`timescale 1ns/10ps
`include "shpf_defines.vh"
module shpf_host_port (
	input wire sys_clk_i,
	input wire rst_n_i,
	// host pins
	input wire cs_n_i,
	input wire rd_n_i,
	input wire wr_n_i,
	input wire cmd_data_sel_i,
	input wire [7:0] host_data_i,
	output wire [7:0] host_data_o,
	output wire host_data_oe_o,
	// port 2 pins
	input wire [7:0] port2_i,
	output wire [7:0] port2_o,
	// core side
	input wire [7:0] core_op_i,
	input wire core_op_valid_i,
	input wire [7:0] core_acc_i,
	input wire core_port2_wr_i,
	input wire [7:0] core_port2_data_i,
	input wire core_obuf_valid_i,
	input wire [7:0] core_obuf_data_i,
	output wire core_obuf_ready_o,
	input wire core_f0_wr_i,
	input wire core_f0_data_i,
	input wire core_ibuf_rd_i,
	output reg [7:0] core_ibuf_data_o,
	output reg core_ibuf_cmd_o,
	output wire [7:0] host_status_o,
	output wire flags_en_o,
	output wire dma_en_o,
	output wire [7:0] port2_sync_o
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg [2:0] cs_sync1_ff, cs_sync2_ff;
	reg [7:0] d_sync1_ff, d_sync2_ff;
	reg [7:0] p2_sync1_ff, p2_sync2_ff;
	reg rd_n_last_ff, wr_n_last_ff;

	// two stages; only stage two feeds logic
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cs_sync1_ff <= 3'h7;
			cs_sync2_ff <= 3'h7;
			d_sync1_ff <= 8'h00;
			d_sync2_ff <= 8'h00;
			p2_sync1_ff <= `SHPF_P2_RST;
			p2_sync2_ff <= `SHPF_P2_RST;
			rd_n_last_ff <= 1'b1;
			wr_n_last_ff <= 1'b1;
		end else begin
			cs_sync1_ff <= {cs_n_i, rd_n_i, wr_n_i};
			cs_sync2_ff <= cs_sync1_ff;
			d_sync1_ff <= host_data_i;
			d_sync2_ff <= d_sync1_ff;
			p2_sync1_ff <= port2_i;
			p2_sync2_ff <= p2_sync1_ff;
			rd_n_last_ff <= cs_sync2_ff[`SHPF_SY_RD];
			wr_n_last_ff <= cs_sync2_ff[`SHPF_SY_WR];
		end
	end

	wire cs_n_s = cs_sync2_ff[`SHPF_SY_CS];
	wire rd_n_s = cs_sync2_ff[`SHPF_SY_RD];
	wire wr_n_s = cs_sync2_ff[`SHPF_SY_WR];
	// a0 and data are synchronised alongside; held stable around strobes
	reg a0_sync1_ff, a0_sync2_ff;
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			a0_sync1_ff <= 1'b0;
			a0_sync2_ff <= 1'b0;
		end else begin
			a0_sync1_ff <= cmd_data_sel_i;
			a0_sync2_ff <= a0_sync1_ff;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// trailing edge of an active-low strobe while selected
	function strobe_done;
		input selected;
		input now_n;
		input last_n;
		begin
			strobe_done = selected & now_n & ~last_n;
		end
	endfunction

	// executed opcode match
	function op_hit;
		input valid;
		input [7:0] code;
		input [7:0] want;
		begin
			op_hit = valid & (code == want);
		end
	endfunction

	// ----------------------------------------
	// mode and select decode
	// ----------------------------------------
	reg flags_en_ff, dma_en_ff, drq_ff;
	reg [7:0] p2_latch_ff;
	wire dma_acknowledge_n_s = p2_sync2_ff[`SHPF_P2_DMA_ACKNOWLEDGE];
	wire sel = ~cs_n_s | (dma_en_ff & ~dma_acknowledge_n_s);
	// a latch low on the ack bit reads as ack for a few clocks after
	// dma mode starts; harmless while both strobes are idle
	wire dma_acknowledge_sel = dma_en_ff & ~dma_acknowledge_n_s;
	// trailing edge of a strobe while selected
	wire rd_done = strobe_done(sel, rd_n_s, rd_n_last_ff);
	wire wr_done = strobe_done(sel, wr_n_s, wr_n_last_ff);
	wire op_ldsts = op_hit(core_op_valid_i, core_op_i, `SHPF_OP_LD_STS);
	wire op_flags = op_hit(core_op_valid_i, core_op_i, `SHPF_OP_EN_FLAGS);
	wire op_dma = op_hit(core_op_valid_i, core_op_i, `SHPF_OP_EN_DMA);

	// ----------------------------------------
	// input direction: host writes into fifo
	// ----------------------------------------
	wire ififo_ready;
	wire ififo_valid;
	wire [8:0] ififo_data;
	// bit 8 carries the command/data mark with the byte
	shpf_fifo #(
		.WIDTH(9),
		.DEPTH(`SHPF_FIFO_DEPTH),
		.AW(`SHPF_FIFO_AW)
	) u_ibuf (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.in_data_i({a0_sync2_ff, d_sync2_ff}),
		.in_valid_i(wr_done),
		.in_ready_o(ififo_ready),
		.out_data_o(ififo_data),
		.out_valid_o(ififo_valid),
		.out_ready_i(core_ibuf_rd_i),
		.level_o()
	);

	// ----------------------------------------
	// status byte
	// ----------------------------------------
	reg obf_ff, ibf_ff, f0_ff, f1_ff;
	reg [3:0] usr_ff;
	reg [7:0] obuf_ff;

	// core read of the input buffer pops one byte
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			core_ibuf_data_o <= 8'h00;
			core_ibuf_cmd_o <= 1'b0;
		end else if (core_ibuf_rd_i & ififo_valid) begin
			core_ibuf_data_o <= ififo_data[7:0];
			core_ibuf_cmd_o <= ififo_data[`SHPF_IB_MARK];
		end
	end

	// ibf mirrors fifo occupancy after the strobe edge
	// writes into a full fifo are dropped; ibf already warns the host
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ibf_ff <= 1'b0;
			f1_ff <= 1'b0;
		end else begin
			if (wr_done) begin
				ibf_ff <= 1'b1;
				f1_ff <= a0_sync2_ff;
			end else begin
				ibf_ff <= ififo_valid;
			end
		end
	end

	// output buffer: a single latch for the host to read
	assign core_obuf_ready_o = ~obf_ff;
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			obf_ff <= 1'b0;
			obuf_ff <= 8'h00;
		end else begin
			if (core_obuf_valid_i & ~obf_ff) begin
				obf_ff <= 1'b1;
				obuf_ff <= core_obuf_data_i;
			end else if (rd_done & (~a0_sync2_ff | dma_acknowledge_sel)) begin
				obf_ff <= 1'b0;
			end
		end
	end

	// user flag and user status bits from the core
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			f0_ff <= 1'b0;
			usr_ff <= 4'h0;
		end else begin
			if (core_f0_wr_i) begin
				f0_ff <= core_f0_data_i;
			end
			if (op_ldsts) begin
				usr_ff <= core_acc_i[`SHPF_ST_USR_HI:`SHPF_ST_USR_LO];
			end
		end
	end

	wire [7:0] status = {usr_ff, f1_ff, f0_ff, ibf_ff, obf_ff};
	assign host_status_o = status;

	// ----------------------------------------
	// host read data path
	// ----------------------------------------
	reg [7:0] rdata_ff;
	reg rdata_oe_ff;
	// a0 high picks status, low picks data; dma always reads data
	// reloaded every clock so a held read sees the latest flags
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 8'h00;
			rdata_oe_ff <= 1'b0;
		end else begin
			rdata_oe_ff <= sel & ~rd_n_s;
			rdata_ff <= (a0_sync2_ff & ~dma_acknowledge_sel) ? status : obuf_ff;
		end
	end
	assign host_data_o = rdata_ff;
	assign host_data_oe_o = rdata_oe_ff;

	// ----------------------------------------
	// port 2 latch, flag pins and dma handshake
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			p2_latch_ff <= `SHPF_P2_RST;
			flags_en_ff <= 1'b0;
			dma_en_ff <= 1'b0;
		end else begin
			if (core_port2_wr_i) begin
				p2_latch_ff <= core_port2_data_i;
			end
			if (op_flags) begin
				flags_en_ff <= 1'b1;
			end
			if (op_dma) begin
				dma_en_ff <= 1'b1;
			end
		end
	end

	// request set by firmware; cleared by enable or ack with a strobe
	// clear wins over set so a firmware write racing the ack cannot
	// leave a stale request behind the finished transfer
	wire drq_set = dma_en_ff & core_port2_wr_i & core_port2_data_i[`SHPF_P2_DRQ];
	wire drq_clr = op_dma | (dma_acknowledge_sel & (~rd_n_s | ~wr_n_s));
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			drq_ff <= 1'b0;
		end else if (drq_clr) begin
			drq_ff <= 1'b0;
		end else if (drq_set) begin
			drq_ff <= 1'b1;
		end
	end

	// pin mux: obf, ibf, drq override the latch when enabled
	// the latch bit gates obf and ibf so firmware can mute either pin; drq is not gated
	reg [7:0] p2_out_ff;
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			p2_out_ff <= `SHPF_P2_RST;
		end else begin
			p2_out_ff <= p2_latch_ff;
			if (flags_en_ff) begin
				p2_out_ff[`SHPF_P2_OBF] <= p2_latch_ff[`SHPF_P2_OBF] & obf_ff;
				p2_out_ff[`SHPF_P2_IBF] <= p2_latch_ff[`SHPF_P2_IBF] & ibf_ff;
			end
			if (dma_en_ff) begin
				p2_out_ff[`SHPF_P2_DRQ] <= drq_ff;
				p2_out_ff[`SHPF_P2_DMA_ACKNOWLEDGE] <= 1'b1; // quasi-bidir high so ack can pull it
			end
		end
	end
	assign port2_o = p2_out_ff;
	assign port2_sync_o = p2_sync2_ff;
	assign flags_en_o = flags_en_ff;
	assign dma_en_o = dma_en_ff;
endmodule

/* File: hdl/shpf_defines.vh */
`ifndef SHPF_DEFINES_VH
`define SHPF_DEFINES_VH
// ----------------------------------------
// status byte layout
// ----------------------------------------
`define SHPF_ST_OBF 0
`define SHPF_ST_IBF 1
`define SHPF_ST_UF0 2
`define SHPF_ST_UF1 3
`define SHPF_ST_USR_LO 4
`define SHPF_ST_USR_HI 7
// ----------------------------------------
// core opcodes
// ----------------------------------------
`define SHPF_OP_LD_STS 8'h90
`define SHPF_OP_EN_FLAGS 8'hf5
`define SHPF_OP_EN_DMA 8'he5
// ----------------------------------------
// port 2 pin positions
// ----------------------------------------
`define SHPF_P2_OBF 4
`define SHPF_P2_IBF 5
`define SHPF_P2_DRQ 6
`define SHPF_P2_DMA_ACKNOWLEDGE 7
// ----------------------------------------
// fifo sizing and reset values
// ----------------------------------------
`define SHPF_FIFO_DEPTH 32
`define SHPF_FIFO_AW 5
`define SHPF_STS_RST 8'h00
`define SHPF_P2_RST 8'hff
// ----------------------------------------
// packed strobe synchroniser and fifo word
// ----------------------------------------
`define SHPF_SY_CS 2
`define SHPF_SY_RD 1
`define SHPF_SY_WR 0
`define SHPF_IB_MARK 8
`endif

/* File: hdl/shpf_fifo.v */
`timescale 1ns/10ps
// ----------------------------------------
// shpf_fifo: synchronous fifo, valid/ready both sides
// ----------------------------------------
module shpf_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [WIDTH-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [AW:0] level_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] cnt_ff;
	wire push;
	wire pop;

	// honest full/empty from the occupancy count
	assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
	assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem[rd_ptr_ff];
	assign level_o = cnt_ff;

	// storage has no reset, pointers do
	always @(posedge sys_clk_i) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data_i;
		end
	end

	// pointer and count update
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
			end
			if (push & ~pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop & ~push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule

/* File: bench/shpf_chk_properties.sv */
`timescale 1ns/10ps
// ----------------
// shpf_chk: port relations
// ----------------
module shpf_chk (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire rd_n_i,
	input wire wr_n_i,
	input wire [7:0] core_op_i,
	input wire core_op_valid_i,
	input wire [7:0] core_acc_i,
	input wire core_obuf_valid_i,
	input wire core_obuf_ready_o,
	input wire [7:0] host_status_o,
	input wire host_data_oe_o,
	input wire flags_en_o,
	input wire dma_en_o,
	input wire [7:0] port2_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// loads accepted only while the output flag is clear
	obf_ready_a: assert property (core_obuf_ready_o == !host_status_o[0])
		else $error("load ready disagrees with output flag");
	obf_set_a: assert property (core_obuf_valid_i && core_obuf_ready_o |=> host_status_o[0])
		else $error("output flag not set by load");
	sts_load_a: assert property (core_op_valid_i && core_op_i == 8'h90 |=>
		host_status_o[7:4] == $past(core_acc_i[7:4]))
		else $error("user status bits not loaded");
	flag_mode_a: assert property (core_op_valid_i && core_op_i == 8'hf5 |=> flags_en_o)
		else $error("flag pin mode not entered");
	dma_mode_a: assert property (core_op_valid_i && core_op_i == 8'he5 |=> dma_en_o)
		else $error("dma mode not entered");
	drq_clear_a: assert property (core_op_valid_i && core_op_i == 8'he5 |->
		##[1:2] !port2_o[6])
		else $error("dma request not cleared");
	// drive only late in a held read strobe
	read_drive_a: assert property ($rose(host_data_oe_o) |-> !rd_n_i && $past(!rd_n_i, 2))
		else $error("bus driven without read");
	// input flag rises only after a write strobe has risen
	ibf_edge_a: assert property ($rose(host_status_o[1]) |->
		$past(wr_n_i, 3) && $past(!wr_n_i, 6))
		else $error("input flag not on trailing edge");
	// output flag drops only after a read strobe has risen
	obf_clear_a: assert property ($fell(host_status_o[0]) |->
		$past(rd_n_i, 3) && $past(!rd_n_i, 6))
		else $error("output flag cleared without read");
endmodule

/* File: bench/shpf_host_model.sv */
`timescale 1ns/10ps
// ----------------
// shpf_host_model: master bus and dma controller
// ----------------
module shpf_host_model (
	input wire sys_clk_i,
	input wire [7:0] host_data_i,
	input wire oe_i,
	output reg cs_n_o,
	output reg rd_n_o,
	output reg wr_n_o,
	output reg a0_o,
	output reg dma_acknowledge_n_o,
	output reg [7:0] data_o
);
	initial begin
		{cs_n_o, rd_n_o, wr_n_o, dma_acknowledge_n_o, a0_o} = 5'h1e;
		data_o = 8'h00;
	end
	// select held past the sync delay, released bus shows inverse
	task xfer(input wr, input a0, input dma, input [7:0] d, output [7:0] q);
		begin
			@(posedge sys_clk_i) #1;
			cs_n_o = dma;
			dma_acknowledge_n_o = !dma;
			a0_o = a0;
			data_o = d;
			wr_n_o = !wr;
			rd_n_o = wr;
			repeat (4) @(posedge sys_clk_i);
			#1 q = oe_i ? host_data_i : 8'hxx;
			{rd_n_o, wr_n_o} = 2'b11;
			repeat (6) @(posedge sys_clk_i);
			#1 {cs_n_o, dma_acknowledge_n_o} = 2'b11;
			data_o = ~d;
		end
	endtask
endmodule

/* File: bench/test_shpf_host_port.sv */
`timescale 1ns/10ps
// ----------------
// test_shpf_host_port: self-checking bench
// ----------------
module test_shpf_host_port;
	reg sys_clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg [7:0] op = 8'h00, acc = 8'h00, p2d = 8'h00, obd = 8'h00, q, d;
	reg opv = 1'b0, p2w = 1'b0, obv = 1'b0, f0w = 1'b0, f0d = 1'b0, ibr = 1'b0;
	wire cs_n, rd_n, wr_n, a0, dma_acknowledge_n, oe, ordy, icmd, fen, den;
	wire [7:0] hdi, hdo, p2o, ist, idat, psy;
	integer err_count = 0, checked = 0, cyc = 0, i;
	reg [8:0] iq[$];
	always #4 sys_clk_i = ~sys_clk_i;
	// hang guard, far above the expected run
	always @(posedge sys_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_count = err_count + 1;
			results;
		end
	end
	shpf_host_port u_shpf_host_port (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .cmd_data_sel_i(a0),
		.host_data_i(hdi), .host_data_o(hdo), .host_data_oe_o(oe),
		.port2_i(p2o & {dma_acknowledge_n, 7'h7f}), .port2_o(p2o), .core_op_i(op),
		.core_op_valid_i(opv), .core_acc_i(acc), .core_port2_wr_i(p2w),
		.core_port2_data_i(p2d), .core_obuf_valid_i(obv), .core_obuf_data_i(obd),
		.core_obuf_ready_o(ordy), .core_f0_wr_i(f0w), .core_f0_data_i(f0d),
		.core_ibuf_rd_i(ibr), .core_ibuf_data_o(idat), .core_ibuf_cmd_o(icmd),
		.host_status_o(ist), .flags_en_o(fen), .dma_en_o(den), .port2_sync_o(psy));
	shpf_host_model u_shpf_host_model (.sys_clk_i(sys_clk_i), .host_data_i(hdo), .oe_i(oe),
		.cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .a0_o(a0), .dma_acknowledge_n_o(dma_acknowledge_n),
		.data_o(hdi));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp)
				$display("Error at %0t: seen %h expected %h", $time, got, exp);
			if (got !== exp)
				err_count = err_count + 1;
		end
	endtask
	// one-cycle core pulse: 0 op, 1 port write, 2 load, 3 user flag, 4 pop
	task core(input integer k, input [7:0] v, input [7:0] a);
		begin
			@(posedge sys_clk_i) #1;
			{op, acc, p2d, obd, f0d} = {v, a, v, v, v[0]};
			{ibr, f0w, obv, p2w, opv} = 5'h01 << k;
			@(posedge sys_clk_i) #1;
			{ibr, f0w, obv, p2w, opv} = 5'h00;
			repeat (2) @(posedge sys_clk_i);
		end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", checked, err_count);
			if (err_count == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		i = $urandom(32'h4d36);
		repeat (20) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		chk({oe, ist, p2o}, 17'h000ff);
		// one write past a full fifo is dropped
		for (i = 0; i < 33; i = i + 1) begin
			d = $urandom;
			u_shpf_host_model.xfer(1, i % 3 == 0, 0, d, q);
			if (iq.size() < 32)
				iq.push_back({i % 3 == 0, d});
			chk({ist[3], ist[1]}, {i % 3 == 0, 1'b1});
		end
		while (iq.size() > 0) begin
			core(4, 0, 0);
			chk({icmd, idat}, iq.pop_front());
		end
		chk(ist[1], 0);
		$display("input test done");
		// second load must be refused while the first waits
		d = $urandom;
		core(2, d, 0);
		core(2, ~d, 0);
		u_shpf_host_model.xfer(0, 1, 0, 0, q);
		chk(q, 8'h01);
		u_shpf_host_model.xfer(0, 0, 0, 0, q);
		chk({q, ordy, ist[0]}, {d, 2'b10});
		d = $urandom;
		core(0, 8'h90, d);
		core(3, 1, 0);
		chk(ist, {d[7:4], 4'b0100});
		chk(psy, 8'hff);
		$display("output test done");
		core(0, 8'hf5, 0);
		core(2, d, 0);
		core(1, 8'h30, 0);
		chk({fen, p2o[5:4]}, 3'b101);
		u_shpf_host_model.xfer(1, 0, 0, d, q);
		chk(p2o[5:4], 2'b11);
		core(1, 8'h00, 0);
		chk(p2o[5:4], 2'b00);
		$display("flag test done");
		core(1, 8'h40, 0);
		chk(p2o[6], 1);
		core(0, 8'he5, 0);
		chk({den, p2o[6]}, 2'b10);
		core(1, 8'h40, 0);
		chk(p2o[6], 1);
		core(0, 8'he5, 0);
		chk(p2o[6], 0);
		core(1, 8'h40, 0);
		chk(p2o[6], 1);
		u_shpf_host_model.xfer(0, 1, 1, 0, q);
		chk({q, p2o[6], ist[0]}, {d, 2'b00});
		$display("dma test done");
		results;
	end
endmodule
bind shpf_host_port shpf_chk u_shpf_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .core_op_i(core_op_i),
	.core_op_valid_i(core_op_valid_i), .core_acc_i(core_acc_i),
	.core_obuf_valid_i(core_obuf_valid_i), .core_obuf_ready_o(core_obuf_ready_o),
	.host_status_o(host_status_o), .host_data_oe_o(host_data_oe_o),
	.flags_en_o(flags_en_o), .dma_en_o(dma_en_o), .port2_o(port2_o));
